/* File: rtl/uhm_pkg.sv */
// Purpose: shared constants and carrier types for the serial port block
// Assumes: 8 data bits, one stop bit, no parity on the line
// Notes:   register indices are word indices; byte address is index times four
package uhm_pkg;
  // structure sizes
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int CNT_W      = 5;
  localparam int ADR_W      = 5;
  localparam int DIV_W      = 16;

  // register word indices
  localparam logic [2:0] REG_DATA        = 3'h0;
  localparam logic [2:0] REG_MASK        = 3'h1;
  localparam logic [2:0] REG_FIFO        = 3'h2;
  localparam logic [2:0] REG_LINE_CTL    = 3'h3;
  localparam logic [2:0] REG_MODEM_CTL   = 3'h4;
  localparam logic [2:0] REG_LINE_STATE  = 3'h5;
  localparam logic [2:0] REG_MODEM_STATE = 3'h6;

  // field positions
  localparam int LCR_DLAB  = 7;
  localparam int MCR_RTS   = 1;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA   = 3;
  localparam int FCR_TRIG  = 6;
  localparam int IM_RX     = 0;
  localparam int IM_THR    = 1;
  localparam int IM_LS     = 2;
  localparam int IM_MODEM  = 3;
  localparam int IM_SLEEP  = 4;
  localparam int IM_XOFF   = 5;
  localparam int IM_RTS    = 6;
  localparam int IM_CTS    = 7;

  // reset values
  localparam logic [7:0]       MASK_RST = 8'h00;
  localparam logic [7:0]       LCR_RST  = 8'h00;
  localparam logic [7:0]       MCR_RST  = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST  = 16'h0001;

  // receive trigger levels in bytes
  localparam logic [CNT_W-1:0] TRIG_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL3 = 5'h0e;

  // interrupt identification codes
  localparam logic [7:0] ID_NONE  = 8'h01;
  localparam logic [7:0] ID_LS    = 8'h06;
  localparam logic [7:0] ID_RX    = 8'h04;
  localparam logic [7:0] ID_THR   = 8'h02;
  localparam logic [7:0] ID_MODEM = 8'h00;
  localparam logic [7:0] ID_XOFF  = 8'h10;
  localparam logic [7:0] ID_FLOW  = 8'h20;
  localparam logic [7:0] ID_FIFO  = 8'hc0;

  // 16x oversampling timing
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // one received character with its line errors
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              frame_err;
    logic              brk;
  } uhm_rx_char_t;
endpackage

/* File: rtl/uhm_port.sv */
// Purpose: serial port top: holding registers, fifos, masks, line state
// Assumes: classic wishbone slave, byte lane 0 carries the registers
// Notes:   ack follows one cycle after a request is taken
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Operation
// - host write loads tx holding when room
// - holding-empty sets when byte moves to shifter
// - write allowed only while a location free
// - rx holding read returns oldest, pops it
// - falling edge, sample start at mid-bit
// - mask bit 7: cts rising raises interrupt
// - mask bit 6: rts rising raises interrupt
// - mask bit 5 gates xoff received interrupt
// - mask bit 4 enables sleep mode
// - mask bit 3 gates modem-status interrupt
// - mask bit 2: interrupt on each received character
// - mask bit 1: interrupt while holding empty
// - mask bit 0: rx trigger-level interrupt
// - ident status tracks trigger, clears together
// - line-state bit 0 set while rx data
// - polled mode reports through line-state bits
// - line-state bits 1, 3 and 4 give receive errors; bit 2 reads zero
// - line-state bit 5 means tx fifo empty
// - line-state bit 6: fifo and shifter empty
// - line-state bit 7: error in rx fifo
// - all mask bits reset to zero
// - enabled sources share one interrupt pin
// - data, mask, fifo and line-state registers only with divisor access clear
module uhm_port
  import uhm_pkg::*;
#(
  parameter logic [DATA_W-1:0] XOFF_CHAR = 8'h13  // flow-control stop character
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADR_W-1:0]  wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_wr,
  output logic      [31:0]       wb_dat_rd,
  output logic                   wb_ack,
  input  wire logic              rxd,
  output logic                   txd,
  input  wire logic              cts_n,
  output logic                   rts_n,
  output logic                   irq,
  output logic                   sleep
);
  typedef struct packed {
    logic [7:0]                          mask;     // interrupt_mask
    logic [7:0]                          line_control;      // line_control
    logic [7:0]                          mcr;      // modem control
    logic                                fifo_en;  // fifo_control enable
    logic                                dma;      // dma mode select
    logic [1:0]                          trig;     // rx trigger select
    logic [DIV_W-1:0]                    dl;       // baud divisor
    logic [DIV_W-1:0]                    bcnt;     // baud counter
    logic                                tick;     // 16x sample tick
    logic [FIFO_DEPTH-1:0][DATA_W-1:0]   tx_mem;   // tx fifo store
    logic [PTR_W-1:0]                    tx_rd;
    logic [PTR_W-1:0]                    tx_wr;
    logic [CNT_W-1:0]                    tx_cnt;
    logic                                tx_load;  // hand byte to shifter
    logic [DATA_W-1:0]                   tx_byte;
    logic [FIFO_DEPTH-1:0][9:0]          rx_mem;   // rx fifo store
    logic [PTR_W-1:0]                    rx_rd;
    logic [PTR_W-1:0]                    rx_wr;
    logic [CNT_W-1:0]                    rx_cnt;
    logic                                overrun;
    logic                                ls_pend;  // char arrived sticky
    logic                                cts_prev;
    logic                                dcts;     // modem status delta
    logic                                cts_rise;
    logic                                rts_pin;
    logic                                rts_rise;
    logic                                xoff;
    logic                                ack;
    logic [31:0]                         dat;
    logic                                irq;
    logic                                sleep;
  } uhm_port_state_t;

  uhm_port_state_t q;         // registered state
  uhm_port_state_t d;         // next state
  logic            tx_busy;   // shifter in use
  uhm_rx_char_t    rx_char;   // character from shifter
  logic            rx_valid;  // character strobe

  // pointer step with wrap
  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = PTR_W'(p + 1'b1);
  endfunction

  // trigger select to byte count
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] s);
    case (s)
      2'h0:    trig_level = TRIG_LVL0;
      2'h1:    trig_level = TRIG_LVL1;
      2'h2:    trig_level = TRIG_LVL2;
      default: trig_level = TRIG_LVL3;
    endcase
  endfunction

  // transmit shifter
  uhm_tx u_tx (
    .clk  (clk),
    .nrst (nrst),
    .tick (q.tick),
    .load (q.tx_load),
    .data (q.tx_byte),
    .txd  (txd),
    .busy (tx_busy)
  );

  // receive shifter
  uhm_rx u_rx (
    .clk      (clk),
    .nrst     (nrst),
    .tick     (q.tick),
    .rxd      (rxd),
    .char_out (rx_char),
    .valid    (rx_valid)
  );

  // next-state logic
  always_comb
  begin
    logic             take;
    logic             wr;
    logic             rd;
    logic             dlab;
    logic [2:0]       idx;
    logic [DATA_W-1:0] wbyte;
    logic [CNT_W-1:0] cap;
    logic             tx_push;
    logic             tx_pop;
    logic             rx_push;
    logic             rx_pop;
    logic             thr_empty;
    logic             temt;
    logic             rx_hit;
    logic             fifo_err;
    logic [PTR_W-1:0] k;
    logic [7:0]       line_state_register;
    logic [7:0]       ident;
    logic [DIV_W-1:0] bnext;
    uhm_rx_char_t     head;
    take     = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    dlab     = 1'b0;
    idx      = 3'h0;
    wbyte    = 8'h00;
    cap      = 5'h01;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    fifo_err = 1'b0;
    k        = '0;
    thr_empty = 1'b0;
    temt     = 1'b0;
    rx_hit   = 1'b0;
    line_state_register      = 8'h00;
    ident    = ID_NONE;
    bnext    = '0;
    head     = '0;
    d        = q;

    // request decode; ack follows one cycle later
    take      = wb_cyc && wb_stb && !q.ack;
    wr        = take && wb_we && wb_sel[0];
    rd        = take && !wb_we;
    idx       = wb_adr[4:2];
    wbyte     = wb_dat_wr[DATA_W-1:0];
    dlab      = q.line_control[LCR_DLAB];
    d.ack     = take;
    d.tx_load = 1'b0;
    d.dat     = 32'h0000_0000;

    // baud tick from divisor
    bnext = DIV_W'(q.bcnt + 16'h0001);
    if (bnext >= q.dl)
    begin
      d.bcnt = 16'h0000;
      d.tick = 1'b1;
    end
    else
    begin
      d.bcnt = bnext;
      d.tick = 1'b0;
    end

    // status terms
    cap       = q.fifo_en ? CNT_W'(FIFO_DEPTH) : 5'h01;
    thr_empty = (q.tx_cnt == 5'h00);
    temt      = thr_empty && !tx_busy && !q.tx_load;
    rx_hit    = q.fifo_en ? (q.rx_cnt >= trig_level(q.trig))
                          : (q.rx_cnt != 5'h00);
    head      = q.rx_mem[q.rx_rd];
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      k = PTR_W'(q.rx_rd + PTR_W'(i));
      if (CNT_W'(i) < q.rx_cnt && (q.rx_mem[k][1] || q.rx_mem[k][0]))
        fifo_err = 1'b1;
    end
    // polled mode reads these bits with all masks clear
    line_state_register = {fifo_err, temt, thr_empty, head.brk && q.rx_cnt != 5'h00,
           head.frame_err && q.rx_cnt != 5'h00, 1'b0, q.overrun,
           q.rx_cnt != 5'h00};

    // identification by priority
    if (q.mask[IM_LS] && q.ls_pend)
      ident = ID_LS;
    else if (q.mask[IM_RX] && rx_hit)
      ident = ID_RX;
    else if (q.mask[IM_THR] && thr_empty)
      ident = ID_THR;
    else if (q.mask[IM_MODEM] && q.dcts)
      ident = ID_MODEM;
    else if (q.mask[IM_XOFF] && q.xoff)
      ident = ID_XOFF;
    else if ((q.mask[IM_CTS] && q.cts_rise) || (q.mask[IM_RTS] && q.rts_rise))
      ident = ID_FLOW;
    else
      ident = ID_NONE;
    if (q.fifo_en)
      ident = ident | ID_FIFO;

    // register reads with their side effects
    if (rd)
    begin
      case (idx)
        REG_DATA:
          if (dlab)
            d.dat[DATA_W-1:0] = q.dl[7:0];
          else
          begin
            d.dat[DATA_W-1:0] = head.data;
            rx_pop = (q.rx_cnt != 5'h00);
          end
        REG_MASK:
          d.dat[DATA_W-1:0] = dlab ? q.dl[15:8] : q.mask;
        REG_FIFO:
          if (!dlab)
          begin
            d.dat[DATA_W-1:0] = ident;
            d.cts_rise = 1'b0;
            d.rts_rise = 1'b0;
            d.xoff     = 1'b0;
          end
        REG_LINE_CTL:
          d.dat[DATA_W-1:0] = q.line_control;
        REG_MODEM_CTL:
          d.dat[DATA_W-1:0] = q.mcr;
        REG_LINE_STATE:
          if (!dlab)
          begin
            d.dat[DATA_W-1:0] = line_state_register;
            d.overrun = 1'b0;
            d.ls_pend = 1'b0;
          end
        REG_MODEM_STATE:
        begin
          d.dat[DATA_W-1:0] = {3'h0, !cts_n, 3'h0, q.dcts};
          d.dcts = 1'b0;
        end
        default: d.dat = 32'h0000_0000;  // unmapped reads zero
      endcase
    end

    // register writes
    if (wr)
    begin
      case (idx)
        REG_DATA:
          if (dlab)
            d.dl[7:0] = wbyte;
          else if (q.tx_cnt < cap)
            tx_push = 1'b1;
        REG_MASK:
          if (dlab)
            d.dl[15:8] = wbyte;
          else
            d.mask = wbyte;
        REG_FIFO:
          if (!dlab)
          begin
            d.fifo_en = wbyte[FCR_EN];
            if (wbyte[FCR_EN])
            begin
              d.dma  = wbyte[FCR_DMA];
              d.trig = wbyte[FCR_TRIG+:2];
            end
          end
        REG_LINE_CTL:
          d.line_control = wbyte;
        REG_MODEM_CTL:
          d.mcr = wbyte;
        default: ;  // unmapped writes ignored
      endcase
    end

    // hand next byte to the idle shifter
    if (!tx_busy && !q.tx_load && q.tx_cnt != 5'h00)
    begin
      tx_pop    = 1'b1;
      d.tx_load = 1'b1;
      d.tx_byte = q.tx_mem[q.tx_rd];
      d.tx_rd   = ptr_next(q.tx_rd);
    end
    if (tx_push)
    begin
      d.tx_mem[q.tx_wr] = wbyte;
      d.tx_wr = ptr_next(q.tx_wr);
    end
    d.tx_cnt = CNT_W'(q.tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop));

    // receive side: store or flag overrun; sets win over clears
    if (rx_valid)
    begin
      d.ls_pend = 1'b1;
      if (rx_char.data == XOFF_CHAR)
        d.xoff = 1'b1;
      if (q.rx_cnt < cap || rx_pop)
        rx_push = 1'b1;
      else
        d.overrun = 1'b1;
    end
    if (rx_pop)
      d.rx_rd = ptr_next(q.rx_rd);
    if (rx_push)
    begin
      d.rx_mem[q.rx_wr] = rx_char;
      d.rx_wr = ptr_next(q.rx_wr);
    end
    d.rx_cnt = CNT_W'(q.rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop));

    // fifo resets, only with the enable written as one
    if (wr && !dlab && idx == REG_FIFO && wbyte[FCR_EN])
    begin
      if (wbyte[FCR_TXRST])
      begin
        d.tx_rd  = '0;
        d.tx_wr  = '0;
        d.tx_cnt = '0;
      end
      if (wbyte[FCR_RXRST])
      begin
        d.rx_rd  = '0;
        d.rx_wr  = '0;
        d.rx_cnt = '0;
      end
    end

    // modem and flow edges
    d.cts_prev = cts_n;
    if (q.cts_prev != cts_n)
      d.dcts = 1'b1;
    if (!q.cts_prev && cts_n)
      d.cts_rise = 1'b1;
    d.rts_pin = !d.mcr[MCR_RTS];
    if (!q.rts_pin && d.rts_pin)
      d.rts_rise = 1'b1;

    // single interrupt pin
    d.irq = (q.mask[IM_RX] && q.fifo_en && rx_hit)
         || (q.mask[IM_RX] && !q.fifo_en && rx_hit)
         || (q.mask[IM_THR] && thr_empty)
         || (q.mask[IM_LS] && q.ls_pend)
         || (q.mask[IM_MODEM] && q.dcts)
         || (q.mask[IM_XOFF] && q.xoff)
         || (q.mask[IM_RTS] && q.rts_rise)
         || (q.mask[IM_CTS] && q.cts_rise);

    // sleep when enabled and nothing is moving
    d.sleep = q.mask[IM_SLEEP] && temt && q.rx_cnt == 5'h00 && rxd;
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q         <= '0;
      q.mask    <= MASK_RST;
      q.line_control     <= LCR_RST;
      q.mcr     <= MCR_RST;
      q.dl      <= DIV_RST;
      q.cts_prev <= 1'b1;
      q.rts_pin <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs straight from state
  assign wb_dat_rd = q.dat;
  assign wb_ack    = q.ack;
  assign rts_n     = q.rts_pin;
  assign irq       = q.irq;
  assign sleep     = q.sleep;
endmodule

/* File: rtl/uhm_rx.sv */
// Purpose: receive shifter with start-bit validation at 16x
// Assumes: rxd synchronous to clk
// Notes:   emits one valid pulse per character when the stop bit is sampled at mid-bit
`timescale 1ns/1ps
module uhm_rx
  import uhm_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   tick,
  input  wire logic   rxd,
  output uhm_rx_char_t char_out,
  output logic        valid
);
  typedef enum logic [1:0] {UHM_RX_IDLE, UHM_RX_START, UHM_RX_DATA, UHM_RX_STOP} uhm_rx_st_t;
  typedef struct packed {
    uhm_rx_st_t        st;
    logic              prev;
    logic [3:0]        tcnt;
    logic [2:0]        bcnt;
    logic [DATA_W-1:0] sh;
    uhm_rx_char_t      ch;
    logic              valid;
  } uhm_rx_state_t;

  uhm_rx_state_t q;  // registered state
  uhm_rx_state_t d;  // next state

  // edge detect and bit sampling
  always_comb
  begin
    d       = q;
    d.prev  = rxd;
    d.valid = 1'b0;
    if (q.st != UHM_RX_IDLE && tick)
      d.tcnt = 4'(q.tcnt + 4'h1);
    case (q.st)
      UHM_RX_IDLE:
        if (q.prev && !rxd)  // falling edge starts the count
        begin
          d.st   = UHM_RX_START;
          d.tcnt = 4'h0;
        end
      UHM_RX_START:
        if (tick && q.tcnt == TICK_MID)
        begin
          if (rxd)
            d.st = UHM_RX_IDLE;  // false start dropped
          else
          begin
            d.st   = UHM_RX_DATA;  // start validated
            d.tcnt = 4'h0;
            d.bcnt = 3'h0;
          end
        end
      UHM_RX_DATA:
        if (tick && q.tcnt == TICK_LAST)
        begin
          d.sh = {rxd, q.sh[DATA_W-1:1]};
          if (q.bcnt == BIT_LAST)
            d.st = UHM_RX_STOP;
          else
            d.bcnt = 3'(q.bcnt + 3'h1);
        end
      UHM_RX_STOP:
        if (tick && q.tcnt == TICK_LAST)
        begin
          d.ch.data      = q.sh;
          d.ch.frame_err = !rxd;
          d.ch.brk       = !rxd && (q.sh == 8'h00);
          d.valid        = 1'b1;
          d.st           = UHM_RX_IDLE;
        end
      default: d.st = UHM_RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q <= '{st: UHM_RX_IDLE, prev: 1'b1, tcnt: 4'h0, bcnt: 3'h0, sh: 8'h00,
             ch: '0, valid: 1'b0};
    else
      q <= d;
  end

  assign char_out = q.ch;
  assign valid    = q.valid;
endmodule

/* File: rtl/uhm_tx.sv */
// Purpose: transmit shifter, start + 8 data + stop at 16 ticks per bit
// Assumes: load only while busy is low
// Notes:   txd idles high
`timescale 1ns/1ps
module uhm_tx
  import uhm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              tick,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] data,
  output logic                   txd,
  output logic                   busy
);
  typedef enum logic [1:0] {UHM_TX_IDLE, UHM_TX_START, UHM_TX_DATA, UHM_TX_STOP} uhm_tx_st_t;
  typedef struct packed {
    uhm_tx_st_t        st;
    logic [3:0]        tcnt;
    logic [2:0]        bcnt;
    logic [DATA_W-1:0] sh;
    logic              txd;
    logic              busy;
  } uhm_tx_state_t;

  uhm_tx_state_t q;  // registered state
  uhm_tx_state_t d;  // next state

  // bit sequencing
  always_comb
  begin
    d = q;
    if (q.st != UHM_TX_IDLE && tick)
      d.tcnt = 4'(q.tcnt + 4'h1);
    case (q.st)
      UHM_TX_IDLE:
      begin
        d.txd = 1'b1;
        if (load)
        begin
          d.sh   = data;
          d.st   = UHM_TX_START;
          d.tcnt = 4'h0;
          d.busy = 1'b1;
          d.txd  = 1'b0;
        end
      end
      UHM_TX_START:
        if (tick && q.tcnt == TICK_LAST)
        begin
          d.st   = UHM_TX_DATA;
          d.bcnt = 3'h0;
          d.txd  = q.sh[0];
        end
      UHM_TX_DATA:
        if (tick && q.tcnt == TICK_LAST)
        begin
          d.sh = {1'b1, q.sh[DATA_W-1:1]};
          if (q.bcnt == BIT_LAST)
          begin
            d.st  = UHM_TX_STOP;
            d.txd = 1'b1;
          end
          else
          begin
            d.bcnt = 3'(q.bcnt + 3'h1);
            d.txd  = q.sh[1];
          end
        end
      UHM_TX_STOP:
        if (tick && q.tcnt == TICK_LAST)
        begin
          d.st   = UHM_TX_IDLE;
          d.busy = 1'b0;
        end
      default: d.st = UHM_TX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q <= '{st: UHM_TX_IDLE, tcnt: 4'h0, bcnt: 3'h0, sh: 8'h00, txd: 1'b1, busy: 1'b0};
    else
      q <= d;
  end

  assign txd  = q.txd;
  assign busy = q.busy;
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for uhm_port
// Assumes: divisor 1, bit of 16 clocks
// Notes:   host side over classic wishbone
`timescale 1ns/1ps
module tb;
  import uhm_pkg::*;
  logic             clk = 0, nrst = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, cts_n = 1;
  logic             wb_ack, txd, rxd, rts_n, irq, sleep;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [31:0]      wb_dat_wr = '0, wb_dat_rd;
  logic [7:0]       q, b;
  int               n_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  uhm_port dut (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(4'h1), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
    .wb_ack(wb_ack), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq),
    .sleep(sleep));
  uhm_line_peer peer (.clk(clk), .rxd(rxd), .txd(txd));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  // one classic cycle, held until ack
  task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d);
    int   n;
    logic ok;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {a, 2'h0};
    wb_dat_wr <= {24'h0, d};
    n = 0;
    // ack is looked at mid-cycle; it then stands at the next rising edge
    do
    begin
      @(negedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    ok = (wb_ack === 1'b1);
    q = wb_dat_rd[7:0];
    @(posedge clk);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("ack", 8'h01, {7'h0, ok});
    if (!ok)
      report_and_stop();
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    bus(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic pin(input string nm, input logic e, ref logic s);
    repeat (3) @(negedge clk);
    chk(nm, {7'h0, e}, {7'h0, s});
  endtask
  task t_reset;
    rd(REG_MASK, MASK_RST, "mask");
    rd(REG_LINE_STATE, 8'h60, "line_state");
    rd(3'h7, 8'h00, "unmapped");
    pin("irq", 1'b0, irq);
    $display("test reset done");
  endtask
  task t_tx;
    wr(REG_LINE_CTL, LCR_RST);
    wr(REG_MASK, 8'h02);
    pin("irq", 1'b1, irq);
    rd(REG_LINE_STATE, 8'h60, "line_state");
    wr(REG_DATA, 8'ha5);
    rd(REG_LINE_STATE, 8'h20, "line_state");
    peer.grab(b);
    chk("txd byte", 8'ha5, b);
    repeat (20) @(posedge clk);
    rd(REG_LINE_STATE, 8'h60, "line_state");
    $display("test tx done");
  endtask
  task t_rx;
    wr(REG_FIFO, 8'h01);
    wr(REG_MASK, 8'h00);
    peer.glitch();
    rd(REG_LINE_STATE, 8'h60, "line_state");
    peer.send(8'h3c);
    rd(REG_LINE_STATE, 8'h61, "line_state");
    rd(REG_DATA, 8'h3c, "rx_holding");
    rd(REG_LINE_STATE, 8'h60, "line_state");
    $display("test rx done");
  endtask
  task t_trig;
    wr(REG_FIFO, 8'h41);
    wr(REG_MASK, 8'h01);
    for (int i = 0; i < 3; i++)
      peer.send(8'h50 + 8'(i));
    pin("irq", 1'b0, irq);
    peer.send(8'h53);
    pin("irq", 1'b1, irq);
    rd(REG_FIFO, ID_RX | ID_FIFO, "ident");
    rd(REG_DATA, 8'h50, "rx_holding");
    pin("irq", 1'b0, irq);
    rd(REG_FIFO, ID_NONE | ID_FIFO, "ident");
    for (int i = 1; i < 4; i++)
      rd(REG_DATA, 8'h50 + 8'(i), "rx_holding");
    $display("test trigger done");
  endtask
  task t_modem;
    wr(REG_MASK, 8'h10);
    pin("sleep", 1'b1, sleep);
    cts_n <= 1'b0;
    wr(REG_MASK, 8'h80);
    pin("sleep", 1'b0, sleep);
    cts_n <= 1'b1;
    pin("irq", 1'b1, irq);
    wr(REG_MODEM_CTL, 8'h02);
    wr(REG_MASK, 8'h40);
    bus(REG_FIFO, 1'b0, 8'h00);
    pin("irq", 1'b0, irq);
    wr(REG_MODEM_CTL, MCR_RST);
    pin("irq", 1'b1, irq);
    $display("test modem done");
  endtask
  task t_flag;
    wr(REG_MASK, 8'h20);
    peer.send(8'h13);
    pin("irq", 1'b1, irq);
    rd(REG_FIFO, ID_XOFF | ID_FIFO, "ident");
    pin("irq", 1'b0, irq);
    wr(REG_MASK, 8'h04);
    pin("irq", 1'b1, irq);
    rd(REG_LINE_STATE, 8'h61, "line_state");
    pin("irq", 1'b0, irq);
    rd(REG_DATA, 8'h13, "rx_holding");
    wr(REG_MASK, 8'h08);
    pin("irq", 1'b1, irq);
    rd(REG_MODEM_STATE, 8'h01, "modem_state");
    pin("irq", 1'b0, irq);
    $display("test flags done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_trig();
    t_modem();
    t_flag();
    report_and_stop();
  end
endmodule

/* File: tb/uhm_line_peer.sv */
// Purpose: far end of the serial line, 8N1 at 16 clocks per bit
// Assumes: divisor 1
// Notes:   line idles high
`timescale 1ns/1ps
module uhm_line_peer
(
  input wire logic clk,
  output logic     rxd,
  input wire logic txd
);
  initial rxd = 1'b1;
  // one frame, lsb first
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
  // short low pulse, gone before mid start bit
  task automatic glitch;
    rxd <= 1'b0;
    repeat (4) @(posedge clk);
    rxd <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  // catch one frame from txd, sampled mid bit
  task automatic grab(output logic [7:0] b);
    int n;
    b = 8'hxx;
    for (n = 0; n < 400 && txd !== 1'b0; n++)
      @(posedge clk);
    repeat (24) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = txd;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule

/* File: tb/uhm_port_assertions.sv */
// Purpose: port checks for the serial port top
// Assumes: one clock, reset low
// Notes:   bound to every uhm_port
`timescale 1ns/1ps
module uhm_port_chk
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic        wb_ack,
  input wire logic [31:0] wb_dat_rd,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq,
  input wire logic        sleep
);
  logic wrote_q;  // some write was acked
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // remembers the first acked write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      wrote_q <= 1'b0;
    else if (wb_ack && wb_we)
      wrote_q <= 1'b1;
  a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not acked next cycle");
  a_ack_has_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack |-> wb_dat_rd[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_quiet: assert property ($rose(nrst) |-> !irq && !sleep)
    else $error("irq or sleep after reset");
  a_irq_needs_write: assert property ($rose(irq) |-> wrote_q)
    else $error("irq before any mask write");
  a_txd_needs_write: assert property ($fell(txd) |-> wrote_q)
    else $error("txd start without data");
  a_sleep_line_low: assert property (!rxd [*3] |-> !sleep)
    else $error("sleep while line busy");
  c_read: cover property (wb_ack && !wb_we);
  c_irq: cover property ($rose(irq));
  c_tx_start: cover property ($fell(txd));
endmodule
bind uhm_port uhm_port_chk chk_i (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_ack(wb_ack), .wb_dat_rd(wb_dat_rd),
  .rxd(rxd), .txd(txd), .irq(irq), .sleep(sleep));
